// *** inc/ecpmc_pkg.sv ***
package ecpmc_pkg;
    // Register byte addresses (printed offsets scaled: 0x401 and 0x402 are not word multiples)
    localparam logic [11:0] IDX_DATA   = 12'h000;
    localparam logic [11:0] IDX_STATUS = 12'h001;
    localparam logic [11:0] IDX_CTRL   = 12'h002;
    localparam logic [11:0] IDX_FIFO   = 12'h400;
    localparam logic [11:0] IDX_CFGB   = 12'h401;
    localparam logic [11:0] IDX_ECR    = 12'h402;
    localparam logic [11:0] IDX_SETUP  = 12'h403;
    localparam logic [13:0] ADDR_DATA   = {IDX_DATA, 2'b00};
    localparam logic [13:0] ADDR_STATUS = {IDX_STATUS, 2'b00};
    localparam logic [13:0] ADDR_CTRL   = {IDX_CTRL, 2'b00};
    localparam logic [13:0] ADDR_FIFO   = {IDX_FIFO, 2'b00};
    localparam logic [13:0] ADDR_CFGB   = {IDX_CFGB, 2'b00};
    localparam logic [13:0] ADDR_ECR    = {IDX_ECR, 2'b00};
    localparam logic [13:0] ADDR_SETUP  = {IDX_SETUP, 2'b00};
    // Mode codes
    localparam logic [2:0] MODE_SPP  = 3'h0;
    localparam logic [2:0] MODE_PS2  = 3'h1;
    localparam logic [2:0] MODE_PFIFO = 3'h2;
    localparam logic [2:0] MODE_ECP  = 3'h3;
    localparam logic [2:0] MODE_EPP  = 3'h4;
    localparam logic [2:0] MODE_TEST = 3'h6;
    localparam logic [2:0] MODE_CFG  = 3'h7;
    // Extended control field positions and reset
    localparam int ECR_MODE_LSB = 5;
    localparam int ECR_FAULT_EN = 4;
    localparam int ECR_DMA_EN   = 3;
    localparam int ECR_SERVICE  = 2;
    localparam int ECR_FULL     = 1;
    localparam int ECR_EMPTY    = 0;
    localparam logic [7:0] ECR_RESET = 8'h15;
    localparam logic [7:0] CFGA_VALUE = 8'h10;
    localparam int FIFO_DEPTH = 16;
    localparam logic [4:0] FIFO_DEPTH_W = 5'h10;
    // Handshake timing: strobe width in ns and in cycles
    localparam int CLK_PERIOD_NS = 5;
    localparam int STROBE_NS = 500;
    localparam logic [7:0] STROBE_CYC = 8'(STROBE_NS / CLK_PERIOD_NS);
    // AXI responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // FIFO entry: tag bit high for address/RLE command
    typedef struct packed {
        logic       cmd;
        logic [7:0] data;
    } ecpmc_entry_t;
    // Parallel control outputs
    typedef struct packed {
        logic strobe_out_low;
        logic auto_feed_out_low;
        logic init_out_low;
        logic printer_select_out_low;
    } ecpmc_ctl_t;
endpackage : ecpmc_pkg

// *** logic/ecpmc_top.sv ***
// Register access over AXI4-Lite is this design's own decision.
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// Operation
// - Compress bit reads 0; bit 6 shows IRQ
// - IRQ select encoded into three-bit field
// - DMA channel encoded into three-bit field
// - Top three extended-control bits select mode
// - ECP mode fault falling edge raises interrupt
// - Enabling fault interrupt while fault asserted interrupts
// - DMA runs only enabled and service clear
// - Service flag blocks DMA and service interrupts
// - Service flag set by TC or thresholds
// - Read-only FIFO full and empty status
// - Standard mode resets FIFO, open-collector controls
// - Bidirectional mode: direction tri-states data lines
// - FIFO mode sends bytes with standard handshake
// - ECP forward merges ports; reverse fills FIFO
// - Modes EPP, test, config mapping, reserved
// - Leave extended modes only to 000/001
// - Modes 011/010 start automatic transfers
// - Return to 000/001 releases controls, drops data
// - Reverse ECP handshakes bytes into FIFO
// - Forward command line low marks command
// - Reverse command line low marks command
// - Read threshold is sixteen minus write threshold
module ecpmc_top (
    // Clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // AXI4-Lite write address and data
    input  wire logic [13:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // AXI4-Lite read
    input  wire logic [13:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // Configuration straps from chip setup
    input  wire logic [3:0]  irq_select,
    input  wire logic [1:0]  dma_select,
    input  wire logic        epp_option_cfg,
    input  wire logic [3:0]  fifo_threshold,
    // Interrupt and DMA side
    input  wire logic        irq_line_level,
    output logic             port_irq,
    output logic             dma_request,
    input  wire logic        dma_ack,
    input  wire logic        dma_tc,
    // Parallel data lines
    input  wire logic [7:0]  pd_in,
    output logic [7:0]       pd_out,
    output logic             pd_oe,
    // Control lines, each with drive enable
    output ecpmc_pkg::ecpmc_ctl_t ctl_out,
    output ecpmc_pkg::ecpmc_ctl_t ctl_oe,
    // Status inputs from the peripheral
    input  wire logic        peripheral_fault_low,
    input  wire logic        ack_in_low,
    input  wire logic        busy_in,
    input  wire logic        perror_in,
    input  wire logic        select_in
);
    ////////////////////////////////////////////////////////////////////////////
    // Input synchronisers
    logic [12:0] sync1_reg;              // First stage
    logic [12:0] sync2_reg;              // Second stage
    always_ff @(posedge aclk) begin
        sync1_reg <= {pd_in, peripheral_fault_low, ack_in_low, busy_in, perror_in, select_in};
        sync2_reg <= sync1_reg;
    end
    logic [7:0] pd_s;
    logic       fault_s, ack_s, busy_s, perror_s, select_s;
    assign {pd_s, fault_s, ack_s, busy_s, perror_s, select_s} = sync2_reg;
    logic irq_s1_reg, irq_s2_reg;        // Interrupt line level sync
    always_ff @(posedge aclk) begin
        irq_s1_reg <= irq_line_level;
        irq_s2_reg <= irq_s1_reg;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Register state
    logic [2:0] mode_reg;                // Operating mode
    logic       fault_en_low_reg;        // Fault interrupt disable when high
    logic       dma_en_reg;              // DMA request enable
    logic       service_reg;             // Service flag
    logic [7:0] data_reg;                // Data port latch
    logic [5:0] dcr_reg;                 // Device control bits
    logic       fault_d_reg;             // Previous fault level
    logic [7:0] last_rd_reg;             // Last byte read from FIFO

    wire dir = dcr_reg[5];
    wire fifo_mode = (mode_reg == ecpmc_pkg::MODE_PFIFO) || (mode_reg == ecpmc_pkg::MODE_ECP);
    wire std_mode  = (mode_reg == ecpmc_pkg::MODE_SPP) || (mode_reg == ecpmc_pkg::MODE_PS2);

    ////////////////////////////////////////////////////////////////////////////
    // FIFO storage
    ecpmc_pkg::ecpmc_entry_t mem [ecpmc_pkg::FIFO_DEPTH];
    logic [3:0] wp_reg, rp_reg;          // Pointers
    logic [4:0] cnt_reg;                 // Bytes held
    wire full  = (cnt_reg == ecpmc_pkg::FIFO_DEPTH_W);
    wire empty = (cnt_reg == 5'h00);
    logic       push, pop;
    ecpmc_pkg::ecpmc_entry_t push_val;

    ////////////////////////////////////////////////////////////////////////////
    // AXI slave handshake
    logic        aw_got_reg, w_got_reg;
    logic [13:0] awaddr_reg;
    logic [31:0] wdata_reg;
    logic [3:0]  wstrb_reg;
    wire do_wr = aw_got_reg && w_got_reg && !s_axi_bvalid;
    wire do_rd = s_axi_arvalid && s_axi_arready;

    // Capture address and data independently
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_got_reg    <= 1'b0;
            w_got_reg     <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            awaddr_reg    <= 14'h0000;
            wdata_reg     <= 32'h0000_0000;
            wstrb_reg     <= 4'h0;
        end else begin
            s_axi_awready <= !aw_got_reg && !s_axi_awready && !do_wr;
            s_axi_wready  <= !w_got_reg && !s_axi_wready && !do_wr;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_got_reg <= 1'b1;
                awaddr_reg <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_got_reg <= 1'b1;
                wdata_reg <= s_axi_wdata;
                wstrb_reg <= s_axi_wstrb;
            end
            if (do_wr) begin
                aw_got_reg <= 1'b0;
                w_got_reg  <= 1'b0;
            end
        end
    end

    // Write decode
    wire wb   = do_wr && wstrb_reg[0];
    wire w_data = wb && awaddr_reg == ecpmc_pkg::ADDR_DATA;
    wire w_ctrl = wb && awaddr_reg == ecpmc_pkg::ADDR_CTRL;
    wire w_fifo = wb && awaddr_reg == ecpmc_pkg::ADDR_FIFO;
    wire w_ecr  = wb && awaddr_reg == ecpmc_pkg::ADDR_ECR;
    wire wr_known = awaddr_reg inside {ecpmc_pkg::ADDR_DATA, ecpmc_pkg::ADDR_STATUS,
        ecpmc_pkg::ADDR_CTRL, ecpmc_pkg::ADDR_FIFO, ecpmc_pkg::ADDR_CFGB,
        ecpmc_pkg::ADDR_ECR};
    wire [2:0] new_mode = wdata_reg[7:5];

    // Write response
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= ecpmc_pkg::RESP_OKAY;
        end else if (do_wr) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_known ? ecpmc_pkg::RESP_OKAY : ecpmc_pkg::RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Extended control register
    wire fault_fall = fault_d_reg && !fault_s;
    logic svc_event;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mode_reg         <= ecpmc_pkg::ECR_RESET[7:5];
            fault_en_low_reg <= ecpmc_pkg::ECR_RESET[ecpmc_pkg::ECR_FAULT_EN];
            dma_en_reg       <= ecpmc_pkg::ECR_RESET[ecpmc_pkg::ECR_DMA_EN];
            service_reg      <= ecpmc_pkg::ECR_RESET[ecpmc_pkg::ECR_SERVICE];
        end else begin
            if (w_ecr) begin
                // Mode change legal only from or to 000/001
                if (std_mode || new_mode == ecpmc_pkg::MODE_SPP ||
                    new_mode == ecpmc_pkg::MODE_PS2)
                    mode_reg <= new_mode;
                fault_en_low_reg <= wdata_reg[ecpmc_pkg::ECR_FAULT_EN];
                dma_en_reg       <= wdata_reg[ecpmc_pkg::ECR_DMA_EN];
                service_reg      <= wdata_reg[ecpmc_pkg::ECR_SERVICE];
            end
            // Hardware set wins over software clear
            if (svc_event)
                service_reg <= 1'b1;
        end
    end

    // Service events
    wire [4:0] free_bytes = ecpmc_pkg::FIFO_DEPTH_W - cnt_reg;
    wire [4:0] wr_thr = {1'b0, fifo_threshold} + 5'h01;
    wire [4:0] rd_thr = ecpmc_pkg::FIFO_DEPTH_W - wr_thr;
    always_comb begin
        svc_event = 1'b0;
        if (!service_reg && fifo_mode) begin
            if (dma_en_reg)
                svc_event = dma_tc && dma_ack;
            else if (!dir)
                svc_event = free_bytes >= wr_thr;
            else
                svc_event = cnt_reg >= rd_thr;
        end
    end

    // Fault interrupt, edge and re-enable cases
    wire fault_irq = (mode_reg == ecpmc_pkg::MODE_ECP) && !fault_en_low_reg && fault_fall;
    wire fault_rearm = w_ecr && fault_en_low_reg &&
                       !wdata_reg[ecpmc_pkg::ECR_FAULT_EN] && !fault_s;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            fault_d_reg <= 1'b1;
            port_irq    <= 1'b0;
        end else begin
            fault_d_reg <= fault_s;
            port_irq    <= fault_irq || fault_rearm || svc_event;
        end
    end

    // DMA request only when enabled and service clear
    always_ff @(posedge aclk) begin
        if (!aresetn)
            dma_request <= 1'b0;
        else
            dma_request <= dma_en_reg && !service_reg && fifo_mode &&
                           (dir ? !empty : !full);
    end

    ////////////////////////////////////////////////////////////////////////////
    // Data and control registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            data_reg <= 8'h00;
            dcr_reg  <= 6'h00;
        end else begin
            if (w_data && std_mode)
                data_reg <= wdata_reg[7:0];
            if (w_ctrl) begin
                dcr_reg[4:0] <= wdata_reg[4:0];
                // Direction changes only in bidirectional mode
                if (mode_reg == ecpmc_pkg::MODE_PS2)
                    dcr_reg[5] <= wdata_reg[5];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Transfer engine
    typedef enum logic [2:0] {ST_IDLE, ST_SETUP, ST_STROBE, ST_WAIT_BUSY,
                              ST_REV_REQ, ST_REV_ACK} ecpmc_st_t;
    ecpmc_st_t  st_reg;
    logic [7:0] tmr_reg;
    ecpmc_pkg::ecpmc_entry_t cur_reg;
    logic       eng_strobe_reg, eng_afd_reg;
    wire fifo_reset = std_mode;
    wire fwd_run = fifo_mode && !dir;
    wire rev_run = (mode_reg == ecpmc_pkg::MODE_ECP) && dir;

    // Push and pop selection
    always_comb begin
        push     = 1'b0;
        pop      = 1'b0;
        push_val = '0;
        if (w_fifo && (fifo_mode || mode_reg == ecpmc_pkg::MODE_TEST) && !full) begin
            push     = 1'b1;
            push_val = '{cmd: 1'b0, data: wdata_reg[7:0]};
        end else if (w_data && mode_reg == ecpmc_pkg::MODE_ECP && !dir && !full) begin
            push     = 1'b1;
            push_val = '{cmd: 1'b1, data: wdata_reg[7:0]};
        end else if (st_reg == ST_REV_ACK && rev_run && !full) begin
            push     = 1'b1;
            push_val = '{cmd: !ack_s, data: pd_s};
        end
        if (st_reg == ST_IDLE && fwd_run && !empty)
            pop = 1'b1;
        else if (do_rd && s_axi_araddr == ecpmc_pkg::ADDR_FIFO && !empty &&
                 (mode_reg == ecpmc_pkg::MODE_TEST || rev_run))
            pop = 1'b1;
    end

    // FIFO pointers and count
    always_ff @(posedge aclk) begin
        if (!aresetn || fifo_reset) begin
            wp_reg  <= 4'h0;
            rp_reg  <= 4'h0;
            cnt_reg <= 5'h00;
        end else begin
            if (push)
                wp_reg <= wp_reg + 4'h1;
            if (pop)
                rp_reg <= rp_reg + 4'h1;
            cnt_reg <= cnt_reg + {4'h0, push} - {4'h0, pop};
        end
    end
    always_ff @(posedge aclk) begin
        if (push)
            mem[wp_reg] <= push_val;
    end

    // Handshake state machine
    always_ff @(posedge aclk) begin
        if (!aresetn || !(fwd_run || rev_run)) begin
            st_reg         <= ST_IDLE;
            tmr_reg        <= 8'h00;
            cur_reg        <= '0;
            eng_strobe_reg <= 1'b0;
            eng_afd_reg    <= 1'b0;
        end else begin
            case (st_reg)
                ST_IDLE: begin
                    if (fwd_run && !empty) begin
                        cur_reg <= mem[rp_reg];
                        // Command marked by low command line
                        eng_afd_reg <= (mode_reg == ecpmc_pkg::MODE_ECP) && mem[rp_reg].cmd;
                        st_reg  <= ST_SETUP;
                    end else if (rev_run && !full) begin
                        eng_afd_reg <= 1'b1;                           // Request byte
                        st_reg      <= ST_REV_REQ;
                    end
                end
                ST_SETUP: begin
                    if (!busy_s) begin
                        eng_strobe_reg <= 1'b1;
                        tmr_reg        <= ecpmc_pkg::STROBE_CYC;
                        st_reg         <= ST_STROBE;
                    end
                end
                ST_STROBE: begin
                    if (tmr_reg == 8'h00 || busy_s) begin
                        eng_strobe_reg <= 1'b0;
                        st_reg         <= ST_WAIT_BUSY;
                    end else
                        tmr_reg <= tmr_reg - 8'h01;
                end
                ST_WAIT_BUSY: begin
                    if (!busy_s) begin
                        eng_afd_reg <= 1'b0;
                        st_reg      <= ST_IDLE;
                    end
                end
                ST_REV_REQ: begin
                    if (!ack_s || busy_s)
                        st_reg <= ST_REV_ACK;
                end
                ST_REV_ACK: begin
                    eng_afd_reg <= 1'b0;                               // Byte taken
                    st_reg      <= ST_IDLE;
                end
                default: st_reg <= ST_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pin drivers
    wire eng_on = fwd_run || rev_run;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pd_out  <= 8'h00;
            pd_oe   <= 1'b1;
            ctl_out <= '1;
            ctl_oe  <= '0;
        end else begin
            pd_out <= eng_on ? cur_reg.data : data_reg;
            // Direction ignored in modes 000 and 010
            pd_oe  <= (mode_reg == ecpmc_pkg::MODE_SPP ||
                       mode_reg == ecpmc_pkg::MODE_PFIFO) ? 1'b1 : !dir;
            ctl_out.strobe_out_low         <= eng_on ? !eng_strobe_reg : !dcr_reg[0];
            ctl_out.auto_feed_out_low      <= eng_on ? !eng_afd_reg : !dcr_reg[1];
            ctl_out.init_out_low           <= dcr_reg[2];
            ctl_out.printer_select_out_low <= !dcr_reg[3];
            // Open collector in 000: drive only the low level
            if (mode_reg == ecpmc_pkg::MODE_SPP) begin
                ctl_oe.strobe_out_low         <= dcr_reg[0];
                ctl_oe.auto_feed_out_low      <= dcr_reg[1];
                ctl_oe.init_out_low           <= !dcr_reg[2];
                ctl_oe.printer_select_out_low <= dcr_reg[3];
            end else
                ctl_oe <= '1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read path
    logic [2:0] irq_code, dma_code;
    always_comb begin
        case (irq_select)
            4'hF:    irq_code = 3'h6;
            4'hE:    irq_code = 3'h5;
            4'hB:    irq_code = 3'h4;
            4'hA:    irq_code = 3'h3;
            4'h9:    irq_code = 3'h2;
            4'h7:    irq_code = 3'h1;
            4'h5:    irq_code = 3'h7;
            default: irq_code = 3'h0;
        endcase
        case (dma_select)
            2'h3:    dma_code = 3'h3;
            2'h2:    dma_code = 3'h2;
            2'h1:    dma_code = 3'h1;
            default: dma_code = 3'h0;
        endcase
    end
    wire cfg = (mode_reg == ecpmc_pkg::MODE_CFG);
    logic [7:0] rd_byte;
    logic       rd_ok;
    always_comb begin
        rd_byte = 8'h00;
        rd_ok   = 1'b1;
        case (s_axi_araddr)
            ecpmc_pkg::ADDR_DATA:   rd_byte = (mode_reg == ecpmc_pkg::MODE_PS2) ?
                                              pd_s : data_reg;
            ecpmc_pkg::ADDR_STATUS: rd_byte = {!busy_s, ack_s, perror_s, select_s,
                                              fault_s, 3'h0};
            ecpmc_pkg::ADDR_CTRL:   rd_byte = {2'h0, dcr_reg};
            ecpmc_pkg::ADDR_FIFO:   rd_byte = cfg ? ecpmc_pkg::CFGA_VALUE :
                                              (empty ? last_rd_reg : mem[rp_reg].data);
            ecpmc_pkg::ADDR_CFGB:   rd_byte = cfg ? {1'b0, irq_s2_reg, irq_code,
                                              dma_code} : 8'h00;
            ecpmc_pkg::ADDR_ECR:    rd_byte = {mode_reg, fault_en_low_reg, dma_en_reg,
                                              service_reg, full, empty};
            ecpmc_pkg::ADDR_SETUP:  rd_byte = {7'h00, epp_option_cfg};
            default:                rd_ok   = 1'b0;
        endcase
    end

    // Read channel
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= ecpmc_pkg::RESP_OKAY;
            last_rd_reg   <= 8'h00;
        end else begin
            s_axi_arready <= !s_axi_arready && !s_axi_rvalid;
            if (do_rd) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= {24'h000000, rd_byte};
                s_axi_rresp  <= rd_ok ? ecpmc_pkg::RESP_OKAY : ecpmc_pkg::RESP_SLVERR;
                if (pop)
                    last_rd_reg <= rd_byte;
            end else if (s_axi_rready)
                s_axi_rvalid <= 1'b0;
        end
    end
endmodule : ecpmc_top

// *** verif/ecpmc_chk.sv ***
`timescale 1ns/1ps
module ecpmc_chk (
    // Watched ports
    input wire logic        aclk, aresetn, s_axi_awready, s_axi_arready,
    input wire logic        s_axi_bvalid, s_axi_bready, s_axi_rvalid, s_axi_rready,
    input wire logic        port_irq, dma_request, dma_ack, dma_tc,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic [31:0] s_axi_rdata,
    input wire ecpmc_pkg::ecpmc_ctl_t ctl_out, ctl_oe
);
default clocking @(posedge aclk); endclocking
default disable iff (!aresetn);
////////////////////////////////////////////////////////////////////////////////
bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
    && $stable(s_axi_bresp)) else $error("write response dropped");
rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
    && $stable(s_axi_rdata)) else $error("read data dropped");
rdata_upper_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("upper read bits set");
aw_pulse_a: assert property (s_axi_awready |=> !s_axi_awready) else $error("awready held");
ar_pulse_a: assert property (s_axi_arready |=> !s_axi_arready) else $error("arready held");
irq_pulse_a: assert property (port_irq |=> !port_irq) else $error("irq not a pulse");
oc_drive_a: assert property (!(&ctl_oe) |-> (ctl_out & ctl_oe) == 4'h0)
    else $error("control driven high");
tc_stop_a: assert property (dma_ack && dma_tc |-> ##[1:6] !dma_request)
    else $error("dma not stopped");
// Main scenarios
cover property (port_irq);
cover property (dma_request);
cover property (!(&ctl_oe));
endmodule : ecpmc_chk
bind ecpmc_top ecpmc_chk i_chk (.*);

// *** verif/ecpmc_printer_model.sv ***
`timescale 1ns/1ps
module ecpmc_printer_model (
    // Host side lines
    input wire logic       aclk, fault_req, pd_oe,
    input wire logic [7:0] pd_out,
    input wire ecpmc_pkg::ecpmc_ctl_t ctl_out, ctl_oe,
    // Peripheral lines
    output logic [7:0]     pd_in,
    output logic           busy_in, ack_in_low, peripheral_fault_low
);
logic [8:0] lg [4];      // Received bytes with command line level
logic [3:0] cnt = 4'h0;  // Bytes received
logic [2:0] hold = 3'h0; // Busy hold time
initial busy_in = 1'b0;
// Undriven control lines rest high on pull-ups
wire st = ctl_out.strobe_out_low | ~ctl_oe.strobe_out_low;
wire af = ctl_out.auto_feed_out_low | ~ctl_oe.auto_feed_out_low;
assign peripheral_fault_low = ~fault_req;
assign ack_in_low = ~(busy_in && hold < 3'h3);
assign pd_in = pd_oe ? pd_out : ~pd_out; // Released lines show no stale byte
// Take a byte on strobe low, answer with busy
always @(posedge aclk) begin
    if (hold != 3'h0) hold <= hold - 3'h1;
    else if (busy_in && st) busy_in <= 1'b0;
    else if (!busy_in && !st) begin
        lg[cnt[1:0]] <= {af, pd_out};
        cnt <= cnt + 4'h1;
        busy_in <= 1'b1;
        hold <= 3'h5;
    end
end
endmodule : ecpmc_printer_model

// *** verif/tb_ecp_port_mode_control.sv ***
`timescale 1ns/1ps
module tb_ecp_port_mode_control;
logic aclk=0, aresetn=0, s_axi_awvalid=0, s_axi_wvalid=0, s_axi_bready=0, s_axi_arvalid=0;
logic s_axi_rready=0, epp_option_cfg=0, irq_line_level=0, dma_ack=0, dma_tc=0, perror_in=0;
logic select_in=0, fault_req=0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
logic s_axi_rvalid, port_irq, dma_request, pd_oe, peripheral_fault_low, ack_in_low, busy_in;
logic [13:0] s_axi_awaddr=0, s_axi_araddr=0;
logic [31:0] s_axi_wdata=0, s_axi_rdata, rv;
logic [3:0]  s_axi_wstrb=4'hF, irq_select=0, fifo_threshold=0;
logic [1:0]  s_axi_bresp, s_axi_rresp, dma_select=0, rr;
logic [7:0]  pd_in, pd_out;
ecpmc_pkg::ecpmc_ctl_t ctl_out, ctl_oe;
int n_compared=0, fail_count=0, ic=0, cyc=0;
localparam logic [13:0] E = ecpmc_pkg::ADDR_ECR;
// Rows: line level, IRQ, DMA channel, expected info byte
logic [14:0] rows [8] = '{15'h3F33, 15'h7A6A, 15'h2D21, 15'h6858,
                          15'h2713, 15'h1E0A, 15'h5579, 15'h0C00};
ecpmc_top i_dut (.*);
ecpmc_printer_model i_p (.*);
initial forever #2.5 aclk = ~aclk;
// Interrupt count and run limit
always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (port_irq === 1'b1) ic <= ic + 1;
    if (cyc == 20000) begin fail_count++; results(); end
end
////////////////////////////////////////////////////////////////////////////////
task automatic chk(input logic [31:0] s, e);
    n_compared++;
    if (s !== e) begin fail_count++; $display("unexpected %0t got %h want %h", $time, s, e); end
endtask : chk
task automatic wr(input logic [13:0] a, input logic [7:0] d);
    @(posedge aclk);
    {s_axi_awaddr, s_axi_wdata} <= {a, 24'h0, d};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    fork
        begin do @(posedge aclk); while (!s_axi_awready); s_axi_awvalid <= 0; end
        begin do @(posedge aclk); while (!s_axi_wready); s_axi_wvalid <= 0; end
    join
    while (!s_axi_bvalid) @(posedge aclk);
    {rr, s_axi_bready} <= {s_axi_bresp, 1'b0};
    @(posedge aclk);
endtask : wr
task automatic rd(input logic [13:0] a);
    @(posedge aclk);
    {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'h3};
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 0;
    while (!s_axi_rvalid) @(posedge aclk);
    {rv, rr, s_axi_rready} <= {s_axi_rdata, s_axi_rresp, 1'b0};
    @(posedge aclk);
endtask : rd
task automatic results;
    $display("compared %0d mismatched %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
endtask : results
////////////////////////////////////////////////////////////////////////////////
initial begin
    repeat (8) @(posedge aclk);
    aresetn <= 1;
    rd(E); chk(rv, ecpmc_pkg::ECR_RESET);
    wr(14'h0010, 8'h00); chk(rr, ecpmc_pkg::RESP_SLVERR);
    wr(E, 8'hF5); wr(E, 8'h75); rd(E); chk(rv[7:5], 3'h7);
    foreach (rows[i]) begin
        {irq_line_level, irq_select, dma_select} <= rows[i][14:8];
        repeat (4) @(posedge aclk);
        rd(ecpmc_pkg::ADDR_CFGB); chk(rv, rows[i][7:0]);
    end
    rd(14'h0010); chk(rr, ecpmc_pkg::RESP_SLVERR);
    $display("end registers");
    wr(E, 8'h15); chk(rr, ecpmc_pkg::RESP_OKAY);
    wr(ecpmc_pkg::ADDR_CTRL, 8'h00); wr(E, 8'h74);
    wr(ecpmc_pkg::ADDR_DATA, 8'h85); wr(ecpmc_pkg::ADDR_FIFO, 8'h3C);
    for (int k = 0; k < 3000 && i_p.cnt < 2; k++) @(posedge aclk);
    chk({i_p.lg[0], i_p.lg[1]}, {9'h085, 9'h13C});
    rd(E); chk(rv[0], 1'b1);
    $display("end forward");
    fault_req <= 1; repeat (8) @(posedge aclk); chk(ic, 0);
    wr(E, 8'h64); repeat (8) @(posedge aclk); chk(ic, 1);
    fault_req <= 0; repeat (8) @(posedge aclk);
    fault_req <= 1; repeat (8) @(posedge aclk); chk(ic, 2);
    $display("end fault");
    wr(E, 8'h6C); repeat (8) @(posedge aclk); chk(dma_request, 0);
    wr(E, 8'h68); repeat (8) @(posedge aclk); chk(dma_request, 1);
    {dma_ack, dma_tc} <= 2'h3; @(posedge aclk); {dma_ack, dma_tc} <= 2'h0;
    repeat (8) @(posedge aclk); chk(ic, 3);
    rd(E); chk(rv[3:2], 2'h3);
    wr(E, 8'h60); repeat (8) @(posedge aclk); chk({dma_request, ic[3:0]}, 5'h04);
    $display("end service");
    wr(E, 8'h15); repeat (400) @(posedge aclk); chk(ctl_out.auto_feed_out_low, 1);
    $display("end return");
    wr(E, 8'h35); wr(ecpmc_pkg::ADDR_CTRL, 8'h20);
    rd(ecpmc_pkg::ADDR_DATA); chk(rv, 8'hFF);
    wr(E, 8'hD5); wr(ecpmc_pkg::ADDR_FIFO, 8'h5A);
    rd(ecpmc_pkg::ADDR_FIFO); chk(rv, 8'h5A);
    rd(ecpmc_pkg::ADDR_FIFO); chk(rv, 8'h5A);
    $display("end modes");
    results();
end
endmodule : tb_ecp_port_mode_control
